// >>> cpu_core_register_file_test.sv
// self-checking bench for the core register set
`include "crf_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module cpu_core_register_file_test;
    logic        clk, rst, wr, rd, go, byte_op, pc_adv;
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic [15:0] opa, opb;
    logic [2:0]  pc_step;
    wire  [31:0] rdata;
    wire         flag_upd, alu_byte, alu_carry, alu_ovf;
    wire  [15:0] alu_result;
    wire  [19:0] pc_out;
    wire  [10:0] flags_out;
    int          num_errors, n_checks;

    crf_core_regs u_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .FLAG_UPD(flag_upd),
        .ALU_BYTE(alu_byte), .ALU_RESULT(alu_result), .ALU_CARRY(alu_carry),
        .ALU_OVF(alu_ovf), .PC_ADV(pc_adv), .PC_STEP(pc_step),
        .PC_OUT(pc_out), .FLAGS_OUT(flags_out));
    crf_alu_model u_alu (.go(go), .byte_op(byte_op), .opa(opa), .opb(opb),
        .FLAG_UPD(flag_upd), .ALU_BYTE(alu_byte), .ALU_RESULT(alu_result),
        .ALU_CARRY(alu_carry), .ALU_OVF(alu_ovf));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [19:0] got, input logic [19:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t out %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic bus_wr_rd(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_rd(rdata, d);
    endtask

    task automatic bus_rd(input logic [4:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_rd(rdata, exp);
    endtask

    function automatic logic [10:0] fl(input logic [3:0] czso);
        logic [10:0] f;
        f = '0;
        f[`CRF_FLAG_C_POS] = czso[3];
        f[`CRF_FLAG_Z_POS] = czso[2];
        f[`CRF_FLAG_S_POS] = czso[1];
        f[`CRF_FLAG_O_POS] = czso[0];
        return f;
    endfunction

    task automatic alu_op(input logic b, input logic [15:0] x,
                          input logic [15:0] y, input logic [10:0] exp);
        @(posedge clk);
        go <= 1'b1;
        byte_op <= b;
        opa <= x;
        opb <= y;
        @(posedge clk);
        go <= 1'b0;
        #1 chk_out(20'(flags_out), 20'(exp));
    endtask

    task automatic t_reset;
        for (int i = 0; i <= 20; i++) bus_rd(5'(i), 32'h0000_0000);
        chk_out(pc_out, 20'h00000);
        chk_out(20'(flags_out), 20'h00000);
    endtask

    task automatic t_words;
        logic [4:0]  ix [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h0A, 5'h0B,
                                 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h13};
        logic [31:0] pat;
        for (int i = 0; i < 12; i++)
            bus_wr(ix[i], {16'hFFFF, 4'h9, 4'(i), 8'h5A});
        for (int i = 0; i < 12; i++) begin
            pat = {16'hFFFF, 4'h9, 4'(i), 8'h5A};
            pat &= (i == 7 || i == 8) ? 32'h000F_FFFF : 32'h0000_FFFF;
            bus_rd(ix[i], pat);
        end
        chk_out(pc_out, 20'hF985A);
    endtask

    task automatic t_bytes;
        bus_wr(5'h00, 32'h0000_1234);
        bus_wr(5'h01, 32'h0000_5678);
        bus_wr(5'h04, 32'hFFFF_FFAB);
        bus_rd(5'h00, 32'h0000_AB34);
        bus_wr(5'h05, 32'hFFFF_FFCD);
        bus_rd(5'h00, 32'h0000_ABCD);
        bus_wr(5'h07, 32'h0000_00EF);
        bus_rd(5'h01, 32'h0000_56EF);
        bus_wr(5'h06, 32'h0000_0021);
        bus_rd(5'h01, 32'h0000_21EF);
        bus_rd(5'h04, 32'h0000_00AB);
        bus_rd(5'h07, 32'h0000_00EF);
        bus_rd(5'h05, 32'h0000_00CD);
        bus_rd(5'h06, 32'h0000_0021);
    endtask

    task automatic t_pairs;
        bus_wr(5'h08, 32'h1111_2222);
        bus_wr(5'h09, 32'h3333_4444);
        bus_wr(5'h0C, 32'h5555_6666);
        bus_rd(5'h00, 32'h0000_2222);
        bus_rd(5'h02, 32'h0000_1111);
        bus_rd(5'h01, 32'h0000_4444);
        bus_rd(5'h03, 32'h0000_3333);
        bus_rd(5'h0A, 32'h0000_6666);
        bus_rd(5'h0B, 32'h0000_5555);
        bus_wr(5'h02, 32'h0000_ABCD);
        bus_rd(5'h08, 32'hABCD_2222);
        bus_rd(5'h09, 32'h3333_4444);
        bus_rd(5'h0C, 32'h5555_6666);
        bus_wr_rd(5'h08, 32'h1357_9BDF);
    endtask

    task automatic t_stack_flags;
        bus_wr(5'h10, 32'h0000_1111);
        bus_wr(5'h11, 32'h0000_2222);
        bus_wr(5'h14, 32'h0000_0080);
        bus_rd(5'h12, 32'h0000_1111);
        bus_wr(5'h14, 32'h0000_0000);
        bus_rd(5'h12, 32'h0000_2222);
        bus_wr(5'h12, 32'h0000_3333);
        bus_rd(5'h11, 32'h0000_3333);
        bus_wr(5'h14, 32'hFFFF_FFFD);
        bus_rd(5'h14, 32'h0000_00BD);
        chk_out(20'(flags_out), 20'h000BD);
        bus_wr(5'h14, 32'h0000_0000);
    endtask

    task automatic t_bank;
        bus_wr(5'h00, 32'h0000_AAAA);
        bus_wr(5'h0A, 32'h0000_BBBB);
        bus_wr(5'h0D, 32'h0000_CCCC);
        bus_wr(5'h13, 32'h0000_DDDD);
        bus_wr(5'h14, 32'h0000_0010);
        bus_rd(5'h00, 32'h0000_0000);
        bus_rd(5'h0A, 32'h0000_0000);
        bus_rd(5'h0D, 32'h0000_0000);
        bus_rd(5'h13, 32'h0000_DDDD);
        bus_wr(5'h00, 32'h0000_5555);
        bus_rd(5'h00, 32'h0000_5555);
        bus_wr(5'h14, 32'h0000_0000);
        bus_rd(5'h00, 32'h0000_AAAA);
        bus_rd(5'h0A, 32'h0000_BBBB);
        bus_rd(5'h0D, 32'h0000_CCCC);
    endtask

    task automatic t_alu;
        alu_op(1'b0, 16'h7FFF, 16'h0001, fl(4'b0011));
        alu_op(1'b0, 16'hFFFF, 16'h0001, fl(4'b1100));
        alu_op(1'b1, 16'h1280, 16'h0080, fl(4'b1101));
        alu_op(1'b1, 16'h0040, 16'h0040, fl(4'b0011));
        alu_op(1'b0, 16'h0001, 16'h0002, fl(4'b0000));
    endtask

    task automatic t_pc_unmapped;
        bus_wr(5'h0F, 32'h000F_FFFE);
        @(posedge clk);
        pc_adv <= 1'b1;
        pc_step <= 3'h3;
        @(posedge clk);
        pc_step <= 3'h7;
        #1 chk_out(pc_out, 20'h00001);
        @(posedge clk);
        pc_adv <= 1'b0;
        #1 chk_out(pc_out, 20'h00008);
        @(posedge clk);
        #1 chk_out(pc_out, 20'h00008);
        bus_wr(5'h1F, 32'hFFFF_FFFF);
        bus_rd(5'h1F, 32'h0000_0000);
        bus_rd(5'h13, 32'h0000_DDDD);
        @(posedge clk);
        #1 chk_rd(rdata, 32'h0000_0000);
    endtask

    task automatic t_reset_again;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk_out(pc_out, 20'h00000);
        chk_out(20'(flags_out), 20'h00000);
        bus_rd(5'h13, 32'h0000_0000);
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        $display("CHECK FAILED %0t run limit reached", $time);
        final_report();
    end

    initial begin
        rst = 1'b1;
        {wr, rd, go, byte_op, pc_adv, pc_step, addr} = '0;
        {wdata, opa, opb} = '0;
        num_errors = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_words();
        t_bytes();
        t_pairs();
        t_stack_flags();
        t_bank();
        t_alu();
        t_pc_unmapped();
        t_reset_again();
        final_report();
    end
endmodule

`default_nettype wire

// >>> crf_alu_model.sv
// datapath model that feeds alu results and flag updates to the register set
`timescale 1ns/1ps
`default_nettype none

module crf_alu_model (
    // operation request from the bench
    input  wire logic        go,
    input  wire logic        byte_op,
    input  wire logic [15:0] opa,
    input  wire logic [15:0] opb,
    // alu outputs
    output logic             FLAG_UPD,
    output logic             ALU_BYTE,
    output logic      [15:0] ALU_RESULT,
    output logic             ALU_CARRY,
    output logic             ALU_OVF
);
    logic [16:0] sum16;
    logic [8:0]  sum8;
    assign sum16 = {1'b0, opa} + {1'b0, opb};
    assign sum8  = {1'b0, opa[7:0]} + {1'b0, opb[7:0]};
    assign FLAG_UPD = go;
    assign ALU_BYTE = byte_op;
    // byte ops leave the upper byte untouched
    assign ALU_RESULT = byte_op ? {opa[15:8], sum8[7:0]} : sum16[15:0];
    assign ALU_CARRY = byte_op ? sum8[8] : sum16[16];
    assign ALU_OVF = byte_op ? (opa[7] == opb[7]) && (sum8[7] != opa[7])
                             : (opa[15] == opb[15]) && (sum16[15] != opa[15]);
endmodule

`default_nettype wire

// >>> crf_core_regs.sv
// programmer-visible register set of a small 16-bit processor core
`include "crf_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module crf_core_regs
    import crf_pkg::*;
#(
    parameter int C_POS = `CRF_FLAG_C_POS,
    parameter int D_POS = `CRF_FLAG_D_POS,
    parameter int Z_POS = `CRF_FLAG_Z_POS,
    parameter int S_POS = `CRF_FLAG_S_POS,
    parameter int B_POS = `CRF_FLAG_B_POS,
    parameter int O_POS = `CRF_FLAG_O_POS,
    parameter int U_POS = `CRF_FLAG_U_POS
) (
    // clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RST,
    // register port
    input  wire logic [`CRF_ADDR_W-1:0] ADDR,
    input  wire logic [`CRF_DATA_W-1:0] WDATA,
    input  wire logic                   WR,
    input  wire logic                   RD,
    output logic      [`CRF_DATA_W-1:0] RDATA,
    // alu flag update
    input  wire logic                   FLAG_UPD,
    input  wire logic                   ALU_BYTE,
    input  wire logic [15:0]            ALU_RESULT,
    input  wire logic                   ALU_CARRY,
    input  wire logic                   ALU_OVF,
    // program counter advance
    input  wire logic                   PC_ADV,
    input  wire logic [2:0]             PC_STEP,
    // live state
    output logic [19:0]                 PC_OUT,
    output logic [10:0]                 FLAGS_OUT
);

    // writable flag bits; every other bit stays zero
    localparam logic [10:0] FLAG_MASK =
        (11'h001 << C_POS) | (11'h001 << D_POS) | (11'h001 << Z_POS) |
        (11'h001 << S_POS) | (11'h001 << B_POS) | (11'h001 << O_POS) |
        (11'h001 << U_POS);

    crf_state_s st;
    crf_state_s next_st;

    logic      bsel;
    crf_word_t sp_active;
    logic      res_zero;
    logic      res_neg;

    assign bsel      = st.cpu_flags[B_POS];
    assign sp_active = st.cpu_flags[U_POS] ? st.user_stack_pointer : st.interrupt_stack_pointer;
    assign res_zero  = ALU_BYTE ? (ALU_RESULT[7:0] == 8'h00)
                                : (ALU_RESULT == 16'h0000);
    assign res_neg   = ALU_BYTE ? ALU_RESULT[7] : ALU_RESULT[15];

    always_comb begin
        next_st       = st;
        next_st.rdata = `CRF_RESET_RDATA;

        // data, address and frame register writes go to the bank the flag selects; the others are unbanked
        if (WR) begin
            if (ADDR == `CRF_IDX_DATA0) begin
                next_st.bank[bsel][`CRF_SLOT_DATA0] = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_DATA1) begin
                next_st.bank[bsel][`CRF_SLOT_DATA1] = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_DATA2) begin
                next_st.bank[bsel][`CRF_SLOT_DATA2] = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_DATA3) begin
                next_st.bank[bsel][`CRF_SLOT_DATA3] = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_D0_UPPER) begin
                next_st.bank[bsel][`CRF_SLOT_DATA0][15:8] = WDATA[7:0];
            end else if (ADDR == `CRF_IDX_D0_LOWER) begin
                next_st.bank[bsel][`CRF_SLOT_DATA0][7:0] = WDATA[7:0];
            end else if (ADDR == `CRF_IDX_D1_UPPER) begin
                next_st.bank[bsel][`CRF_SLOT_DATA1][15:8] = WDATA[7:0];
            end else if (ADDR == `CRF_IDX_D1_LOWER) begin
                next_st.bank[bsel][`CRF_SLOT_DATA1][7:0] = WDATA[7:0];
            end else if (ADDR == `CRF_IDX_PAIR_LOW) begin
                next_st.bank[bsel][`CRF_SLOT_DATA2] = WDATA[31:16];
                next_st.bank[bsel][`CRF_SLOT_DATA0] = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_PAIR_HIGH) begin
                next_st.bank[bsel][`CRF_SLOT_DATA3] = WDATA[31:16];
                next_st.bank[bsel][`CRF_SLOT_DATA1] = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_ADDR0) begin
                next_st.bank[bsel][`CRF_SLOT_ADDR0] = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_ADDR1) begin
                next_st.bank[bsel][`CRF_SLOT_ADDR1] = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_ADDR_LONG) begin
                next_st.bank[bsel][`CRF_SLOT_ADDR1] = WDATA[31:16];
                next_st.bank[bsel][`CRF_SLOT_ADDR0] = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_FRAME_BASE) begin
                next_st.bank[bsel][`CRF_SLOT_FRAME] = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_VECTOR_BASE) begin
                next_st.vbase = WDATA[19:0];
            end else if (ADDR == `CRF_IDX_PROG_CNT) begin
                next_st.pc = WDATA[19:0];
            end else if (ADDR == `CRF_IDX_USER_SP) begin
                next_st.user_stack_pointer = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_INTR_SP) begin
                next_st.interrupt_stack_pointer = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_ACTIVE_SP) begin
                if (st.cpu_flags[U_POS]) begin
                    next_st.user_stack_pointer = WDATA[15:0];
                end else begin
                    next_st.interrupt_stack_pointer = WDATA[15:0];
                end
            end else if (ADDR == `CRF_IDX_STATIC_BASE) begin
                next_st.sbase = WDATA[15:0];
            end else if (ADDR == `CRF_IDX_FLAGS) begin
                // debug bit is stored as written; software keeps it clear
                next_st.cpu_flags = WDATA[10:0] & FLAG_MASK;
            end
        end

        // a bus write to the program counter beats an advance
        if (PC_ADV && !(WR && ADDR == `CRF_IDX_PROG_CNT)) begin
            next_st.pc = st.pc + {17'h00000, PC_STEP};
        end

        // alu outcome overrides a same-cycle flag write for its own bits
        if (FLAG_UPD) begin
            next_st.cpu_flags[C_POS] = ALU_CARRY;
            next_st.cpu_flags[Z_POS] = res_zero;
            next_st.cpu_flags[S_POS] = res_neg;
            next_st.cpu_flags[O_POS] = ALU_OVF;
        end

        // read data stands only in the cycle after the strobe
        if (RD) begin
            if (ADDR == `CRF_IDX_DATA0) begin
                next_st.rdata = {16'h0000, st.bank[bsel][`CRF_SLOT_DATA0]};
            end else if (ADDR == `CRF_IDX_DATA1) begin
                next_st.rdata = {16'h0000, st.bank[bsel][`CRF_SLOT_DATA1]};
            end else if (ADDR == `CRF_IDX_DATA2) begin
                next_st.rdata = {16'h0000, st.bank[bsel][`CRF_SLOT_DATA2]};
            end else if (ADDR == `CRF_IDX_DATA3) begin
                next_st.rdata = {16'h0000, st.bank[bsel][`CRF_SLOT_DATA3]};
            end else if (ADDR == `CRF_IDX_D0_UPPER) begin
                next_st.rdata = {24'h000000,
                                 st.bank[bsel][`CRF_SLOT_DATA0][15:8]};
            end else if (ADDR == `CRF_IDX_D0_LOWER) begin
                next_st.rdata = {24'h000000,
                                 st.bank[bsel][`CRF_SLOT_DATA0][7:0]};
            end else if (ADDR == `CRF_IDX_D1_UPPER) begin
                next_st.rdata = {24'h000000,
                                 st.bank[bsel][`CRF_SLOT_DATA1][15:8]};
            end else if (ADDR == `CRF_IDX_D1_LOWER) begin
                next_st.rdata = {24'h000000,
                                 st.bank[bsel][`CRF_SLOT_DATA1][7:0]};
            end else if (ADDR == `CRF_IDX_PAIR_LOW) begin
                next_st.rdata = {st.bank[bsel][`CRF_SLOT_DATA2],
                                 st.bank[bsel][`CRF_SLOT_DATA0]};
            end else if (ADDR == `CRF_IDX_PAIR_HIGH) begin
                next_st.rdata = {st.bank[bsel][`CRF_SLOT_DATA3],
                                 st.bank[bsel][`CRF_SLOT_DATA1]};
            end else if (ADDR == `CRF_IDX_ADDR0) begin
                next_st.rdata = {16'h0000, st.bank[bsel][`CRF_SLOT_ADDR0]};
            end else if (ADDR == `CRF_IDX_ADDR1) begin
                next_st.rdata = {16'h0000, st.bank[bsel][`CRF_SLOT_ADDR1]};
            end else if (ADDR == `CRF_IDX_ADDR_LONG) begin
                next_st.rdata = {st.bank[bsel][`CRF_SLOT_ADDR1],
                                 st.bank[bsel][`CRF_SLOT_ADDR0]};
            end else if (ADDR == `CRF_IDX_FRAME_BASE) begin
                next_st.rdata = {16'h0000, st.bank[bsel][`CRF_SLOT_FRAME]};
            end else if (ADDR == `CRF_IDX_VECTOR_BASE) begin
                next_st.rdata = {12'h000, st.vbase};
            end else if (ADDR == `CRF_IDX_PROG_CNT) begin
                next_st.rdata = {12'h000, st.pc};
            end else if (ADDR == `CRF_IDX_USER_SP) begin
                next_st.rdata = {16'h0000, st.user_stack_pointer};
            end else if (ADDR == `CRF_IDX_INTR_SP) begin
                next_st.rdata = {16'h0000, st.interrupt_stack_pointer};
            end else if (ADDR == `CRF_IDX_ACTIVE_SP) begin
                next_st.rdata = {16'h0000, sp_active};
            end else if (ADDR == `CRF_IDX_STATIC_BASE) begin
                next_st.rdata = {16'h0000, st.sbase};
            end else if (ADDR == `CRF_IDX_FLAGS) begin
                next_st.rdata = {21'h000000, st.cpu_flags};
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st.bank  <= '0;
            st.vbase <= `CRF_RESET_WORD20;
            st.pc    <= `CRF_RESET_WORD20;
            st.user_stack_pointer   <= `CRF_RESET_WORD16;
            st.interrupt_stack_pointer   <= `CRF_RESET_WORD16;
            st.sbase <= `CRF_RESET_WORD16;
            st.cpu_flags   <= `CRF_RESET_FLAGS;
            st.rdata <= `CRF_RESET_RDATA;
        end else begin
            st <= next_st;
        end
    end

    assign RDATA     = st.rdata;
    assign PC_OUT    = st.pc;
    assign FLAGS_OUT = st.cpu_flags;

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_data_write;
        logic b;
        (WR && ADDR == `CRF_IDX_DATA2, b = bsel) |=>
            st.bank[b][`CRF_SLOT_DATA2] == $past(WDATA[15:0]);
    endproperty
    a_data_write: assert property (p_data_write)
        else $error("data word two not written");

    property p_byte_upper;
        (WR && ADDR == `CRF_IDX_D0_UPPER) |=>
            st.bank[$past(bsel)][`CRF_SLOT_DATA0][7:0] ==
            $past(st.bank[bsel][`CRF_SLOT_DATA0][7:0]);
    endproperty
    a_byte_upper: assert property (p_byte_upper)
        else $error("upper byte write disturbed lower byte");

    sequence s_pair_low_write;
        WR && ADDR == `CRF_IDX_PAIR_LOW ##1 RD && ADDR == `CRF_IDX_PAIR_LOW
            && !FLAG_UPD;
    endsequence
    property p_pair_round_trip;
        s_pair_low_write |=> RDATA == $past(WDATA, 2);
    endproperty
    a_pair_round_trip: assert property (p_pair_round_trip)
        else $error("low pair did not read back");

    property p_addr_long;
        (WR && ADDR == `CRF_IDX_ADDR_LONG) |=>
            st.bank[$past(bsel)][`CRF_SLOT_ADDR1] == $past(WDATA[31:16]);
    endproperty
    a_addr_long: assert property (p_addr_long)
        else $error("upper address half wrong");

    property p_read_only_after_strobe;
        !RD |=> RDATA == 32'h0000_0000;
    endproperty
    a_read_only_after_strobe: assert property (p_read_only_after_strobe)
        else $error("read data outside its cycle");

    property p_pc_advance;
        (PC_ADV && !(WR && ADDR == `CRF_IDX_PROG_CNT)) |=>
            PC_OUT == 20'($past(PC_OUT) + 20'($past(PC_STEP)));
    endproperty
    a_pc_advance: assert property (p_pc_advance)
        else $error("program counter did not advance");

    property p_active_sp;
        (RD && ADDR == `CRF_IDX_ACTIVE_SP) |=>
            RDATA[15:0] == ($past(st.cpu_flags[U_POS]) ? $past(st.user_stack_pointer)
                                                  : $past(st.interrupt_stack_pointer));
    endproperty
    a_active_sp: assert property (p_active_sp)
        else $error("wrong stack pointer selected");

    property p_zero_sign;
        FLAG_UPD |=> FLAGS_OUT[Z_POS] == $past(res_zero)
                  && FLAGS_OUT[S_POS] == $past(res_neg);
    endproperty
    a_zero_sign: assert property (p_zero_sign)
        else $error("zero or sign flag wrong");

    property p_carry_ovf;
        FLAG_UPD |=> FLAGS_OUT[C_POS] == $past(ALU_CARRY)
                  && FLAGS_OUT[O_POS] == $past(ALU_OVF);
    endproperty
    a_carry_ovf: assert property (p_carry_ovf)
        else $error("carry or overflow flag wrong");

    property p_bank_isolation;
        (WR && ADDR == `CRF_IDX_DATA0 && !bsel) |=>
            $stable(st.bank[1][`CRF_SLOT_DATA0]);
    endproperty
    a_bank_isolation: assert property (p_bank_isolation)
        else $error("bank 0 write reached bank 1");

    property p_flag_unlisted;
        (FLAGS_OUT & ~FLAG_MASK) == 11'h000;
    endproperty
    a_flag_unlisted: assert property (p_flag_unlisted)
        else $error("unlisted flag bit set");

    property p_ptr_write;
        logic b;
        (WR && ADDR == `CRF_IDX_ADDR0, b = bsel) |=>
            st.bank[b][`CRF_SLOT_ADDR0] == $past(WDATA[15:0]);
    endproperty
    a_ptr_write: assert property (p_ptr_write)
        else $error("address pointer zero not written");

    property p_frame_write;
        logic b;
        (WR && ADDR == `CRF_IDX_FRAME_BASE, b = bsel) |=>
            st.bank[b][`CRF_SLOT_FRAME] == $past(WDATA[15:0]);
    endproperty
    a_frame_write: assert property (p_frame_write)
        else $error("frame base not written");

    property p_vector_write;
        (WR && ADDR == `CRF_IDX_VECTOR_BASE) |=>
            st.vbase == $past(WDATA[19:0]);
    endproperty
    a_vector_write: assert property (p_vector_write)
        else $error("vector table base not written");

    property p_pc_write;
        (WR && ADDR == `CRF_IDX_PROG_CNT) |=> PC_OUT == $past(WDATA[19:0]);
    endproperty
    a_pc_write: assert property (p_pc_write)
        else $error("program counter not written");

    property p_static_write;
        (WR && ADDR == `CRF_IDX_STATIC_BASE) |=>
            st.sbase == $past(WDATA[15:0]);
    endproperty
    a_static_write: assert property (p_static_write)
        else $error("static base not written");

endmodule

`default_nettype wire

// >>> crf_defines.svh
// register indices, field positions and reset values of the core register file
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH

`define CRF_ADDR_W          5
`define CRF_DATA_W          32

`define CRF_IDX_DATA0       5'h00
`define CRF_IDX_DATA1       5'h01
`define CRF_IDX_DATA2       5'h02
`define CRF_IDX_DATA3       5'h03
`define CRF_IDX_D0_UPPER    5'h04
`define CRF_IDX_D0_LOWER    5'h05
`define CRF_IDX_D1_UPPER    5'h06
`define CRF_IDX_D1_LOWER    5'h07
`define CRF_IDX_PAIR_LOW    5'h08
`define CRF_IDX_PAIR_HIGH   5'h09
`define CRF_IDX_ADDR0       5'h0A
`define CRF_IDX_ADDR1       5'h0B
`define CRF_IDX_ADDR_LONG   5'h0C
`define CRF_IDX_FRAME_BASE  5'h0D
`define CRF_IDX_VECTOR_BASE 5'h0E
`define CRF_IDX_PROG_CNT    5'h0F
`define CRF_IDX_USER_SP     5'h10
`define CRF_IDX_INTR_SP     5'h11
`define CRF_IDX_ACTIVE_SP   5'h12
`define CRF_IDX_STATIC_BASE 5'h13
`define CRF_IDX_FLAGS       5'h14

`define CRF_SLOT_DATA0      0
`define CRF_SLOT_DATA1      1
`define CRF_SLOT_DATA2      2
`define CRF_SLOT_DATA3      3
`define CRF_SLOT_ADDR0      4
`define CRF_SLOT_ADDR1      5
`define CRF_SLOT_FRAME      6
`define CRF_BANK_SLOTS      7
`define CRF_BANKS           2

`define CRF_FLAG_C_POS      0
`define CRF_FLAG_D_POS      1
`define CRF_FLAG_Z_POS      2
`define CRF_FLAG_S_POS      3
`define CRF_FLAG_B_POS      4
`define CRF_FLAG_O_POS      5
`define CRF_FLAG_U_POS      7

`define CRF_RESET_WORD16    16'h0000
`define CRF_RESET_WORD20    20'h00000
`define CRF_RESET_FLAGS     11'h000
`define CRF_RESET_RDATA     32'h0000_0000

`endif

// >>> crf_pkg.sv
// types of the core register file
`default_nettype none
`include "crf_defines.svh"

package crf_pkg;

    typedef logic [15:0] crf_word_t;
    typedef logic [19:0] crf_addr20_t;

    typedef struct packed {
        crf_word_t [`CRF_BANKS-1:0][`CRF_BANK_SLOTS-1:0] bank;
        crf_addr20_t                                      vbase;
        crf_addr20_t                                      pc;
        crf_word_t                                        user_stack_pointer;
        crf_word_t                                        interrupt_stack_pointer;
        crf_word_t                                        sbase;
        logic [10:0]                                      cpu_flags;
        logic [`CRF_DATA_W-1:0]                           rdata;
    } crf_state_s;

endpackage

`default_nettype wire
